// >>> cgpll_pkg.sv
`default_nettype none
package cgpll_pkg;
	localparam int N_W = 4;
	localparam int L_W = 4;
	localparam logic [3:0] N_RST = 4'h1;
	localparam logic [3:0] L_RST = 4'h0;
	// nominal vco centre step in khz
	localparam int F_NOM_KHZ = 4915;
	localparam int SWITCH_CYC = 3;
	// lock window: reference periods counted per measurement, tolerances in feedback edges
	localparam int MEAS_REFS = 16;
	localparam int LOCK_TOL = 1;
	localparam int TRK_TOL = 2;
	typedef enum logic [1:0] {
		CGPLL_MODE_ACQ = 2'b01,
		CGPLL_MODE_TRK = 2'b10
	} cgpll_mode_t;
endpackage
`default_nettype wire

// >>> cgpll_div.sv
`default_nettype none
// modulo divider: one tick every n input ticks; n of zero acts as one
module cgpll_div #(
	parameter int W = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic tick_in,
	input wire logic [W-1:0] n_in,
	output logic tick_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] n_eff;
	logic wrap;
	assign n_eff = (n_in == '0) ? W'(1) : n_in;
	assign wrap = tick_in && (cnt_r >= n_eff - W'(1));
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			cnt_r <= '0;
			tick_out <= 1'b0;
		end else if (ce_in) begin
			tick_out <= wrap;
			if (wrap)
				cnt_r <= '0;
			else if (tick_in)
				cnt_r <= cnt_r + W'(1);
		end
	end
endmodule
`default_nettype wire

// >>> cgpll_sel.sv
`default_nettype none
// glitch-free source switch: holds output static while waiting on the crystal clock, and on the vco clock too when selecting it
module cgpll_sel (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic xtal_tick_in,
	input wire logic vco_tick_in,
	input wire logic sel_vco_in,
	output logic base_clock_out,
	output logic active_vco_out,
	output logic busy_out
);
	logic [1:0] xcnt_r;
	logic [1:0] vcnt_r;
	logic src_tick;
	logic done;
	assign busy_out = (sel_vco_in != active_vco_out);
	assign src_tick = active_vco_out ? vco_tick_in : xtal_tick_in;
	assign done = (xcnt_r == 2'(cgpll_pkg::SWITCH_CYC)) && (vcnt_r == 2'(cgpll_pkg::SWITCH_CYC));
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			xcnt_r <= '0;
			vcnt_r <= '0;
			active_vco_out <= 1'b0;
			base_clock_out <= 1'b0;
		end else if (ce_in) begin
			if (busy_out) begin
				if (xtal_tick_in && xcnt_r != 2'(cgpll_pkg::SWITCH_CYC))
					xcnt_r <= xcnt_r + 2'h1;
				if (vco_tick_in && vcnt_r != 2'(cgpll_pkg::SWITCH_CYC))
					vcnt_r <= vcnt_r + 2'h1;
				if (done || (!sel_vco_in && xcnt_r == 2'(cgpll_pkg::SWITCH_CYC))) begin
					active_vco_out <= sel_vco_in;
					xcnt_r <= '0;
					vcnt_r <= '0;
				end
			end else if (src_tick) begin
				base_clock_out <= ~base_clock_out;
			end
		end
	end
endmodule
`default_nettype wire

// >>> cgpll_top.sv
// Function
// - base clock is crystal or vco clock halved, software selects source.
// - crystal clock runs only while oscillator enable is high.
// - pll reference is buffered crystal clock, same rate as final reference.
// - vco clock divided by programmable n forms feedback clock.
// - phase detector emits up or down pulse from phase difference.
// - lock detector compares feedback and reference frequencies per reference window.
// - acquisition mode allows large corrections; mode flag reads clear.
// - tracking mode whenever not acquiring or mode flag set.
// - enter tracking once vco frequency nearly correct.
// - mode switch automatic or manual per bandwidth control.
// - interrupt on entering and leaving lock.
// - vco centre equals l times nominal step, range half to twice.
// - source switch waits three crystal ticks, plus three vco ticks when selecting vco, output held.
// - auto mode makes flag read-only; manual disables lock and interrupt.
// - n zero acts as one; l zero disables pll, forces crystal.
// - no vco select while off, no off while selected, no simultaneous change.
`default_nettype none
module cgpll_top #(
	parameter int N_W = cgpll_pkg::N_W,
	parameter int L_W = cgpll_pkg::L_W
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic osc_enable_in,
	input wire logic osc_in_pin_in,
	input wire logic vco_clock_in,
	input wire logic wr_ctrl_in,
	input wire logic base_clock_select_in,
	input wire logic pll_power_on_in,
	input wire logic lock_irq_enable_in,
	input wire logic auto_bw_in,
	input wire logic acq_track_flag_in,
	input wire logic wr_prog_in,
	input wire logic [N_W-1:0] mul_n_in,
	input wire logic [L_W-1:0] lin_l_in,
	output logic osc_out_pin_out,
	output logic crystal_clock_out,
	output logic base_clock_out,
	output logic pll_ref_clock_out,
	output logic final_ref_clock_out,
	output logic vco_feedback_clock_out,
	output logic pump_up_out,
	output logic pump_dn_out,
	output logic [L_W+12:0] vco_centre_khz_out,
	output logic wide_bw_out,
	output logic base_clock_select_out,
	output logic pll_power_on_out,
	output logic acq_track_flag_out,
	output logic lock_out,
	output logic lock_irq_flag_out,
	output logic clock_gen_irq_out,
	output logic switch_busy_out
);
	// elaboration-time refusal of widths the 8-bit window counters cannot serve
	if (N_W < 1 || N_W > 8 || L_W < 1 || L_W > 8) begin : g_width_check
		$error("cgpll_top: divider widths out of range");
	end

	logic xtal_q_r;
	logic vco_q_r;
	logic bcs_r;
	logic pon_r;
	logic acq_r;
	logic lock_r;
	logic ie_r;
	logic irq_r;
	logic [N_W-1:0] n_r;
	logic [L_W-1:0] l_r;
	logic [7:0] win_r;
	logic [7:0] fb_cnt_r;
	logic lock_raw_r;
	logic trk_raw_r;
	logic up_r;
	logic dn_r;
	logic fb_tick;
	logic xtal_tick;
	logic vco_tick;
	logic vco_tick_raw;
	logic pll_en;
	logic sel_busy;
	logic sel_active;
	logic pon_chg;
	logic bcs_chg;
	logic win_end;
	logic [7:0] err;
	logic [7:0] fb_next;
	logic acq_nxt;
	logic lock_nxt;

	function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// crystal runs only when enabled
	assign crystal_clock_out = osc_in_pin_in & osc_enable_in;
	assign osc_out_pin_out = ~crystal_clock_out & osc_enable_in;
	assign pll_ref_clock_out = crystal_clock_out;
	assign final_ref_clock_out = pll_ref_clock_out;
	assign xtal_tick = osc_enable_in & osc_in_pin_in & ~xtal_q_r;
	assign pll_en = pon_r && (l_r != '0);
	assign vco_tick_raw = pll_en & vco_clock_in & ~vco_q_r;
	assign vco_tick = vco_tick_raw;
	assign fb_tick = vco_feedback_clock_out;
	assign pon_chg = pll_power_on_in != pon_r;
	assign bcs_chg = base_clock_select_in != bcs_r;
	assign vco_centre_khz_out = (L_W+13)'(l_r) * (L_W+13)'(cgpll_pkg::F_NOM_KHZ);
	assign wide_bw_out = !acq_r;
	assign base_clock_select_out = bcs_r;
	assign pll_power_on_out = pon_r;
	assign acq_track_flag_out = acq_r;
	assign lock_out = lock_r;
	assign lock_irq_flag_out = irq_r;
	assign clock_gen_irq_out = irq_r && ie_r && auto_bw_in;
	assign switch_busy_out = sel_busy;
	assign pump_up_out = up_r;
	assign pump_dn_out = dn_r;
	assign win_end = xtal_tick && (win_r == 8'(cgpll_pkg::MEAS_REFS - 1));
	assign fb_next = fb_cnt_r + (fb_tick ? 8'h01 : 8'h00);
	assign err = absdiff(fb_next, 8'(cgpll_pkg::MEAS_REFS));
	// lock, and tracking in auto mode, decided per measurement window; the first stage holds its own
	// value between windows so the synchronised copy does not pulse for one cycle
	assign lock_nxt = auto_bw_in && pll_en && win_end ? (err <= 8'(cgpll_pkg::LOCK_TOL))
		: (lock_raw_r && auto_bw_in && pll_en);
	assign acq_nxt = !pll_en ? 1'b0
		: auto_bw_in ? (win_end ? (err <= 8'(cgpll_pkg::TRK_TOL)) : trk_raw_r)
		: (wr_ctrl_in ? acq_track_flag_in : trk_raw_r);

	cgpll_div #(
		.W(N_W)
	) u_div (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.tick_in(vco_tick),
		.n_in(n_r),
		.tick_out(vco_feedback_clock_out)
	);

	cgpll_sel u_sel (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.xtal_tick_in(xtal_tick),
		.vco_tick_in(vco_tick),
		.sel_vco_in(bcs_r && pll_en),
		.base_clock_out(base_clock_out),
		.active_vco_out(sel_active),
		.busy_out(sel_busy)
	);

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			xtal_q_r <= 1'b0;
			vco_q_r <= 1'b0;
			up_r <= 1'b0;
			dn_r <= 1'b0;
		end else if (ce_in) begin
			xtal_q_r <= osc_enable_in & osc_in_pin_in;
			vco_q_r <= pll_en & vco_clock_in;
			// phase detector: set on own edge, both set cancels
			if (xtal_tick && fb_tick) begin
				up_r <= up_r;
				dn_r <= dn_r;
			end else if (up_r && dn_r) begin
				up_r <= 1'b0;
				dn_r <= 1'b0;
			end else begin
				up_r <= pll_en && (up_r ? !fb_tick : xtal_tick);
				dn_r <= pll_en && (dn_r ? !xtal_tick : fb_tick);
			end
		end
	end

	// control register with refusal of illegal writes
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			bcs_r <= 1'b0;
			pon_r <= 1'b1;
			ie_r <= 1'b0;
			n_r <= N_W'(cgpll_pkg::N_RST);
			l_r <= L_W'(cgpll_pkg::L_RST);
		end else if (ce_in) begin
			if (wr_ctrl_in) begin
				ie_r <= lock_irq_enable_in;
				if (!(pon_chg && bcs_chg)) begin
					if (!(pon_r && !pll_power_on_in && bcs_r))
						pon_r <= pll_power_on_in;
					if (!(base_clock_select_in && (!pon_r || l_r == '0)))
						bcs_r <= base_clock_select_in;
				end
			end else if (l_r == '0) begin
				bcs_r <= 1'b0;
			end
			if (wr_prog_in) begin
				n_r <= mul_n_in;
				l_r <= lin_l_in;
			end
		end
	end

	// lock detector state and lock-change flag
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			win_r <= '0;
			fb_cnt_r <= '0;
			lock_raw_r <= 1'b0;
			trk_raw_r <= 1'b0;
			acq_r <= 1'b0;
			lock_r <= 1'b0;
			irq_r <= 1'b0;
		end else if (ce_in) begin
			if (win_end) begin
				win_r <= '0;
				fb_cnt_r <= '0;
			end else begin
				if (xtal_tick)
					win_r <= win_r + 8'h01;
				fb_cnt_r <= fb_next;
			end
			lock_raw_r <= lock_nxt;
			trk_raw_r <= acq_nxt;
			lock_r <= lock_raw_r;
			acq_r <= trk_raw_r;
			if (auto_bw_in && lock_raw_r != lock_r)
				irq_r <= 1'b1;
			else if (wr_ctrl_in || !auto_bw_in)
				irq_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> cgpll_top_assertions.sv
`default_nettype none
module cgpll_chk #(
	parameter int N_W = 4,
	parameter int L_W = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic osc_enable_in,
	input wire logic osc_in_pin_in,
	input wire logic wr_ctrl_in,
	input wire logic wr_prog_in,
	input wire logic auto_bw_in,
	input wire logic [L_W-1:0] lin_l_in,
	input wire logic crystal_clock_out,
	input wire logic base_clock_out,
	input wire logic [L_W+12:0] vco_centre_khz_out,
	input wire logic wide_bw_out,
	input wire logic base_clock_select_out,
	input wire logic pll_power_on_out,
	input wire logic acq_track_flag_out,
	input wire logic lock_out,
	input wire logic lock_irq_flag_out,
	input wire logic clock_gen_irq_out,
	input wire logic switch_busy_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	property p_xtal; crystal_clock_out == (osc_in_pin_in & osc_enable_in); endproperty
	a_xtal: assert property (p_xtal) else $error("crystal gate wrong");
	property p_centre; wr_prog_in |=> vco_centre_khz_out == $past(lin_l_in) * 4915; endproperty
	a_centre: assert property (p_centre) else $error("centre wrong");
	property p_bw; wide_bw_out == !acq_track_flag_out; endproperty
	a_bw: assert property (p_bw) else $error("filter mode wrong");
	property p_irq_man; !auto_bw_in |-> !clock_gen_irq_out; endproperty
	a_irq_man: assert property (p_irq_man) else $error("irq in manual");
	property p_lock_irq; $rose(lock_out) && auto_bw_in |-> ##[0:1] lock_irq_flag_out; endproperty
	a_lock_irq: assert property (p_lock_irq) else $error("no lock flag");
	property p_sel_pll; base_clock_select_out |-> pll_power_on_out; endproperty
	a_sel_pll: assert property (p_sel_pll) else $error("vco selected while off");
	property p_hold; switch_busy_out && $past(switch_busy_out) |-> $stable(base_clock_out); endproperty
	a_hold: assert property (p_hold) else $error("base moved while switching");
	property p_busy; $rose(switch_busy_out) |-> ##[1:300] !switch_busy_out; endproperty
	a_busy: assert property (p_busy) else $error("switch never ends");
endmodule
bind cgpll_top cgpll_chk #(.N_W(N_W), .L_W(L_W)) i_cgpll_chk (.core_clk_in(core_clk_in),
	.rst_in(rst_in), .osc_enable_in(osc_enable_in), .osc_in_pin_in(osc_in_pin_in),
	.wr_ctrl_in(wr_ctrl_in), .wr_prog_in(wr_prog_in), .auto_bw_in(auto_bw_in),
	.lin_l_in(lin_l_in), .crystal_clock_out(crystal_clock_out), .base_clock_out(base_clock_out),
	.vco_centre_khz_out(vco_centre_khz_out), .wide_bw_out(wide_bw_out),
	.base_clock_select_out(base_clock_select_out), .pll_power_on_out(pll_power_on_out),
	.acq_track_flag_out(acq_track_flag_out), .lock_out(lock_out),
	.lock_irq_flag_out(lock_irq_flag_out), .clock_gen_irq_out(clock_gen_irq_out),
	.switch_busy_out(switch_busy_out));
`default_nettype wire

// >>> cgpll_sim_model.sv
`default_nettype none
module cgpll_sim_model (
	input wire logic core_clk_in,
	input wire logic osc_enable_in,
	output logic xtal_out,
	output logic vco_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ph = 4'h0;
	always @(posedge core_clk_in) ph <= ph + 4'h1;
	// uneven crystal duty, low while the oscillator is off
	assign xtal_out = osc_enable_in && (ph < 4'h5);
	// vco at twice the crystal rate
	assign vco_out = ph[2:0] < 3'h3;
endmodule
`default_nettype wire

// >>> clock_generator_pll_select_test.sv
`default_nettype none
module clock_generator_pll_select_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, osc_en = 1'b1, wr_c = 1'b0, wr_p = 1'b0, auto = 1'b1, pb = 1'b0;
	logic [3:0] ctl = 4'h2, n = 4'h1, l = 4'h0;
	logic xtal, vco, base, busy, sel, on, acq_track_flag, lock, irq;
	logic [16:0] centre, tg = 17'h0;
	logic [20:0] q[$];
	logic [20:0] e;
	logic [31:0] r;
	int seed = 36, fails = 0, n_checks = 0;
	wire logic [4:0] st = {irq, acq_track_flag, lock, on, sel};
	cgpll_sim_model i_cgpll_sim_model (.core_clk_in(clk), .osc_enable_in(osc_en),
		.xtal_out(xtal), .vco_out(vco));
	cgpll_top i_cgpll_top (.core_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .osc_enable_in(osc_en),
		.osc_in_pin_in(xtal), .vco_clock_in(vco), .wr_ctrl_in(wr_c), .base_clock_select_in(ctl[0]),
		.pll_power_on_in(ctl[1]), .lock_irq_enable_in(ctl[2]), .auto_bw_in(auto),
		.acq_track_flag_in(ctl[3]), .wr_prog_in(wr_p), .mul_n_in(n), .lin_l_in(l),
		.osc_out_pin_out(), .crystal_clock_out(), .base_clock_out(base), .pll_ref_clock_out(),
		.final_ref_clock_out(), .vco_feedback_clock_out(), .pump_up_out(), .pump_dn_out(),
		.vco_centre_khz_out(centre), .wide_bw_out(), .base_clock_select_out(sel),
		.pll_power_on_out(on), .acq_track_flag_out(acq_track_flag), .lock_out(lock),
		.lock_irq_flag_out(), .clock_gen_irq_out(irq), .switch_busy_out(busy));
	function automatic logic [16:0] obs(input logic [3:0] k);
		obs = (k == 4'h0) ? centre : (k == 4'h1) ? tg : {16'h0, st[k - 4'h2]};
	endfunction
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [3:0] k, input logic [16:0] v);
		q.push_back({k, v});
		@(negedge clk);
	endtask
	task automatic wc(input logic [3:0] c);
		@(posedge clk);
		wr_c <= 1'b1;
		ctl <= c;
		@(posedge clk);
		wr_c <= 1'b0;
	endtask
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		if (base !== pb) tg <= tg + 17'h1;
		pb <= base;
	end
	always @(negedge clk) begin
		while (q.size() > 0) begin
			e = q.pop_front();
			n_checks++;
			if (obs(e[20:17]) !== e[16:0]) begin
				fails++;
				$display("unexpected at %0t got %h want %h", $time, obs(e[20:17]), e[16:0]);
			end
		end
	end
	initial begin
		#(20000 * 40);
		fails++;
		test_done;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(4'h2, 17'h0);
		chk(4'h3, 17'h1);
		chk(4'h0, 17'h0);
		wc(4'h3);
		chk(4'h2, 17'h0);
		$display("test reset done");
		r = $random(seed);
		@(posedge clk);
		wr_p <= 1'b1;
		n <= 4'h2;
		l <= r[3:0] | 4'h1;
		@(posedge clk);
		wr_p <= 1'b0;
		chk(4'h0, {13'h0, r[3:0] | 4'h1} * 17'h1333);
		// select and power-off in one write
		wc(4'h1);
		chk(4'h2, 17'h0);
		chk(4'h3, 17'h1);
		$display("test program done");
		wc(4'h6);
		for (int i = 0; i < 3000 && lock !== 1'b1; i++) @(posedge clk);
		@(negedge clk);
		chk(4'h4, 17'h1);
		chk(4'h6, 17'h1);
		chk(4'h5, 17'h1);
		$display("test lock done");
		wc(4'h7);
		chk(4'h2, 17'h1);
		for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk);
		@(negedge clk);
		tg = 17'h0;
		repeat (64) @(posedge clk);
		chk(4'h1, 17'h8);
		wc(4'h5);
		chk(4'h3, 17'h1);
		chk(4'h2, 17'h1);
		$display("test select done");
		@(posedge clk);
		auto <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			wc({i[0], 3'h7});
			repeat (2) @(posedge clk);
			chk(4'h5, {16'h0, i[0]});
		end
		chk(4'h6, 17'h0);
		$display("test manual done");
		test_done;
	end
endmodule
`default_nettype wire
